// ### src/general_timer_unit.sv
// general timer unit: first module (aux_timer_a, core_timer, aux_timer_b), second module (capture_timer, base_timer)
//
// Notes on behaviour
// - five 16-bit timers in two modules; timers chain within their own module
// - each first-module timer selects timer, gated, counter or incremental mode
// - timer mode counts prescaled clock, finest one count per 4 clocks
// - counter mode advances on edges of the timer input pin
// - gated mode counts prescaled clocks only while the pin level enables it
// - software sets direction; optionally the direction pin flips it live
// - incremental mode derives count and direction from quadrature inputs A and B
// - core toggle latch inverts on each core wrap and may drive its pin
// - core toggle latch can clock either auxiliary timer
// - an auxiliary timer in capture or reload role does not count
// - capture role latches core value on the auxiliary timer's pin edge
// - reload role loads core from auxiliary on pin edge or latch transition
// - two auxiliaries on opposite latch edges alternate reloads, giving free PWM
// - second module has two timers and capture register, finest 2 clocks
// - second-module timers run on prescaled clock or external signals
// - base toggle latch inverts on base wrap, clocks capture timer, drives pin
// - base wraps go out to the compare unit and may reload base from capture register
// - capture_input_pin edge latches capture timer into capture register, optional clear after
// - capture may also trigger on core count or direction input edges
//
// The address map and the plain strobed port are this design's own decisions.
module general_timer_unit #(
  parameter int PRE_W = 10
) (
  input  wire  logic           clock,
  input  wire  logic           arst_n,
  input  wire  gtu_pkg::pins_t pins,
  input  wire  logic [3:0]     addr,
  input  wire  logic [15:0]    wdata,
  input  wire  logic           we,
  input  wire  logic           re,
  output logic [15:0]          rdata,
  output logic                 core_toggle_output,
  output logic                 core_toggle_oe,
  output logic                 base_toggle_output,
  output logic                 base_toggle_oe,
  output logic                 base_wrap_pulse
);
  import gtu_pkg::*;
  `include "gtu_defines.svh"

  ////////////////////////////////////////////////////////////////////////////
  // state and shared wires
  ctrl_t        ctrl_ff [5];
  ctrl_t        nxt_ctrl [5];
  logic [15:0]  cnt_ff [5];
  logic [15:0]  nxt_cnt [5];
  logic [15:0]  capture_reload_register_ff;
  logic [15:0]  nxt_capture_reload_register;
  logic [PRE_W-1:0] pre_ff;
  pins_t        s1_ff;
  pins_t        s2_ff;
  pins_t        pv_ff;
  logic         core_latch_ff;
  logic         base_latch_ff;
  logic         wrap_ff;
  logic [15:0]  rdata_ff;
  logic [4:0]   step;
  logic [4:0]   down;
  logic [4:0]   wrap;
  logic [4:0]   cap_ev;
  logic [4:0]   rld_ev;
  logic [4:0]   cin_r;
  logic [4:0]   cin_f;
  logic [4:0]   din_r;
  logic [4:0]   din_f;
  logic         cap_r;
  logic         cap_f;
  logic         core_rise;
  logic         core_fall;
  logic         base_rise;
  logic         base_fall;
  logic         cap2;
  ctrl_t        c3;
  logic [3:0]   cidx;
  logic [15:0]  rd_word;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////////////////////
  // pin edges from the synchronised copies
  assign cin_r = s2_ff.cnt_in & ~pv_ff.cnt_in;
  assign cin_f = ~s2_ff.cnt_in & pv_ff.cnt_in;
  assign din_r = s2_ff.dir_in & ~pv_ff.dir_in;
  assign din_f = ~s2_ff.dir_in & pv_ff.dir_in;
  assign cap_r = s2_ff.cap_in & ~pv_ff.cap_in;
  assign cap_f = ~s2_ff.cap_in & pv_ff.cap_in;

  // toggle latch transitions, seen in the cycle of the wrap
  // decoding the edge from the wrap itself puts a reload in the same cycle as the toggle
  assign core_rise = wrap[1] & ~core_latch_ff;
  assign core_fall = wrap[1] & core_latch_ff;
  assign base_rise = wrap[4] & ~base_latch_ff;
  assign base_fall = wrap[4] & base_latch_ff;

  ////////////////////////////////////////////////////////////////////////////
  // per-timer count logic
  for (genvar g = 0; g < 5; g++) begin : g_tmr
    localparam logic [9:0] STEP  = (g < 3) ? `GTU_M1_STEP : `GTU_M2_STEP;
    localparam logic [3:0] A_CTL = 4'(`GTU_REG_CTRL0 + g);
    localparam logic [3:0] A_CNT = 4'(`GTU_REG_CNT0 + g);
    ctrl_t       c;
    role_t       role;
    logic [9:0]  mask;
    logic        tick;
    logic        pin;
    logic        dpin;
    logic        l_r;
    logic        l_f;
    logic        s_r;
    logic        s_f;
    logic        inc;
    logic        quad;
    logic        quad_up;
    logic        stopped;
    logic        ld_en;
    logic [15:0] ld_val;
    logic [15:0] stepped;

    assign c    = ctrl_ff[g];
    assign role = role_t'(c.opt);
    assign pin  = s2_ff.cnt_in[g];
    assign dpin = s2_ff.dir_in[g];

    // prescaler tap: period STEP << pre clocks
    // the prescaler runs free, so a newly started timer may wait up to one period
    assign mask = 10'((STEP << c.pre) - 10'h001);
    assign tick = (10'(pre_ff) & mask) == 10'h000;

    // latch clock source for chained timers
    if (g == 0 || g == 2) begin : g_lat
      assign l_r = core_rise;
      assign l_f = core_fall;
    end else if (g == 3) begin : g_lat
      assign l_r = base_rise;
      assign l_f = base_fall;
    end else begin : g_lat
      assign l_r = 1'b0;
      assign l_f = 1'b0;
    end
    assign s_r = c.clk_latch ? l_r : cin_r[g];
    assign s_f = c.clk_latch ? l_f : cin_f[g];

    // quadrature decode: A edge up when A differs from B, B edge up when equal
    // x4 decode: every edge of A or B is one step; a missed edge costs one count
    assign quad    = (g < 3) && c.mode == MODE_INCR;
    assign quad_up = (cin_r[g] | cin_f[g]) ? (pin != dpin) : (pin == dpin);

    // count event by mode
    assign inc = (c.mode == MODE_TIMER) ? tick
               : (c.mode == MODE_GATED) ? (tick & (pin == c.gate_lvl))
               : quad ? (cin_r[g] | cin_f[g] | din_r[g] | din_f[g])
               : edge_hit(c.edge_sel, s_r, s_f);
    assign stopped = (g == 0 || g == 2) && role != ROLE_NONE;
    assign step[g] = c.run & ~stopped & inc;
    assign down[g] = quad ? (quad_up == c.down) : (c.down ^ (c.ext_dir & dpin));
    assign wrap[g] = step[g] & (cnt_ff[g] == (down[g] ? 16'h0000 : `GTU_CNT_MAX));
    assign stepped = down[g] ? cnt_ff[g] - 16'h0001 : cnt_ff[g] + 16'h0001;

    // capture, reload and clear loads
    if (g == 0 || g == 2) begin : g_ld
      assign cap_ev[g] = role == ROLE_CAPTURE && edge_hit(c.edge_sel, cin_r[g], cin_f[g]);
      assign rld_ev[g] = role == ROLE_RELOAD &&
                         ((c.trig_sel == TRIG_PIN && edge_hit(c.edge_sel, cin_r[g], cin_f[g])) ||
                          (c.trig_sel == TRIG_LATCH_RISE && core_rise) ||
                          (c.trig_sel == TRIG_LATCH_FALL && core_fall));
      assign ld_en  = cap_ev[g];
      assign ld_val = cnt_ff[1];
    end else begin : g_ld
      assign cap_ev[g] = 1'b0;
      assign rld_ev[g] = 1'b0;
      if (g == 1) begin : g_core
        assign ld_en  = rld_ev[0] | rld_ev[2];
        assign ld_val = rld_ev[0] ? cnt_ff[0] : cnt_ff[2];
      end else if (g == 3) begin : g_cap
        assign ld_en  = cap2 & c.opt[`GTU_OPT_CLEAR];
        assign ld_val = `GTU_CNT_RST;
      end else begin : g_base
        assign ld_en  = wrap[4] & c.opt[`GTU_OPT_RELOAD];
        assign ld_val = capture_reload_register_ff;
      end
    end

    // software write wins over hardware activity
    // loads win over a step in the same cycle, so a wrap that also reloads never lands one count off
    assign nxt_cnt[g]  = (we && addr == A_CNT) ? wdata
                       : ld_en ? ld_val
                       : step[g] ? stepped
                       : cnt_ff[g];
    assign nxt_ctrl[g] = (we && addr == A_CTL) ? ctrl_t'(wdata) : ctrl_ff[g];
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture register of the second module
  assign c3   = ctrl_ff[3];
  assign cap2 = edge_hit(c3.trig_sel, cap_r, cap_f)
              | (c3.opt[`GTU_OPT_TRIG_IN] & (cin_r[1] | cin_f[1]))
              | (c3.gate_lvl & (din_r[1] | din_f[1]));
  assign nxt_capture_reload_register = (we && addr == `GTU_REG_CAPTURE_RELOAD_REGISTER) ? wdata : cap2 ? cnt_ff[3] : capture_reload_register_ff;

  ////////////////////////////////////////////////////////////////////////////
  // read decode, unmapped offsets read zero
  // status is read only; a write to its offset changes nothing
  assign cidx    = addr - `GTU_REG_CNT0;
  assign rd_word = (addr < `GTU_REG_CNT0) ? ctrl_ff[addr[2:0]]
                 : (addr < `GTU_REG_CAPTURE_RELOAD_REGISTER) ? cnt_ff[cidx[2:0]]
                 : (addr == `GTU_REG_CAPTURE_RELOAD_REGISTER) ? capture_reload_register_ff
                 : (addr == `GTU_REG_STATUS) ? {14'h0000, base_latch_ff, core_latch_ff}
                 : 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  // the pin levels follow the latches at once; software owns the enables
  assign rdata              = rdata_ff;
  assign core_toggle_output = core_latch_ff;
  assign core_toggle_oe     = ctrl_ff[1].opt[`GTU_OPT_OE];
  assign base_toggle_output = base_latch_ff;
  assign base_toggle_oe     = ctrl_ff[4].opt[`GTU_OPT_OE];
  assign base_wrap_pulse    = wrap_ff;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge history
  // pv_ff reads only the second stage, so a metastable first stage never reaches logic
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s1_ff <= '0;
      s2_ff <= '0;
      pv_ff <= '0;
    end else begin
      s1_ff <= pins;
      s2_ff <= s1_ff;
      pv_ff <= s2_ff;
    end
  end

  // timers, controls and capture register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 5; i++) begin
        cnt_ff[i]  <= `GTU_CNT_RST;
        ctrl_ff[i] <= ctrl_t'(`GTU_CTRL_RST);
      end
      capture_reload_register_ff <= `GTU_CNT_RST;
    end else begin
      for (int i = 0; i < 5; i++) begin
        cnt_ff[i]  <= nxt_cnt[i];
        ctrl_ff[i] <= nxt_ctrl[i];
      end
      capture_reload_register_ff <= nxt_capture_reload_register;
    end
  end

  // prescaler, toggle latches, wrap pulse and read data
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pre_ff        <= '0;
      core_latch_ff <= 1'b0;
      base_latch_ff <= 1'b0;
      wrap_ff       <= 1'b0;
      rdata_ff      <= 16'h0000;
    end else begin
      pre_ff        <= pre_ff + 1'b1;
      core_latch_ff <= core_latch_ff ^ wrap[1];
      base_latch_ff <= base_latch_ff ^ wrap[4];
      wrap_ff       <= wrap[4];
      rdata_ff      <= re ? rd_word : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_core_latch_flip: assert property (wrap[1] |=> core_latch_ff != $past(core_latch_ff))
    else $error("core latch missed a wrap");
  a_m1_resolution: assert property ((ctrl_ff[1].mode == MODE_TIMER && step[1]) |-> pre_ff[1:0] == 2'b00)
    else $error("core timer stepped finer than 4 clocks");
  a_m2_resolution: assert property ((ctrl_ff[4].mode == MODE_TIMER && step[4]) |-> pre_ff[0] == 1'b0)
    else $error("base timer stepped finer than 2 clocks");
  a_aux_role_hold: assert property ((role_t'(ctrl_ff[0].opt) == ROLE_RELOAD && !we) |=>
                                    cnt_ff[0] == $past(cnt_ff[0]))
    else $error("aux timer counted in reload role");
  a_core_capture: assert property ((cap_ev[0] && !we) |=> cnt_ff[0] == $past(cnt_ff[1]))
    else $error("capture into aux_a wrong");
  a_core_reload: assert property ((rld_ev[2] && !rld_ev[0] && !we) |=> cnt_ff[1] == $past(cnt_ff[2]))
    else $error("reload from aux_b wrong");
  a_gate_hold: assert property ((ctrl_ff[1].mode == MODE_GATED && s2_ff.cnt_in[1] != ctrl_ff[1].gate_lvl
                                 && !we && !rld_ev[0] && !rld_ev[2]) |=> cnt_ff[1] == $past(cnt_ff[1]))
    else $error("gated core counted while gate closed");
  a_incr_up: assert property ((ctrl_ff[1].mode == MODE_INCR && ctrl_ff[1].run && !ctrl_ff[1].down
                               && cin_r[1] && !s2_ff.dir_in[1] && !we && !rld_ev[0] && !rld_ev[2])
                              |=> cnt_ff[1] == 16'($past(cnt_ff[1]) + 16'h0001))
    else $error("quadrature A rise with B low did not count up");
  a_capture_reload_register_grab: assert property ((cap2 && !we) |=> capture_reload_register_ff == $past(cnt_ff[3]))
    else $error("capture register missed capture timer value");
  a_base_wrap_out: assert property (wrap[4] |=> base_wrap_pulse ##1 (base_wrap_pulse == $past(wrap[4])))
    else $error("base wrap pulse not forwarded");
  c_pwm_alternate: cover property (rld_ev[0] ##[1:1000] rld_ev[2]);
  c_capture_reload_register_capture: cover property (cap2 && ctrl_ff[3].opt[`GTU_OPT_CLEAR]);
  c_incr_down: cover property (step[1] && down[1] && ctrl_ff[1].mode == MODE_INCR);
  c_base_reload: cover property (wrap[4] && ctrl_ff[4].opt[`GTU_OPT_RELOAD]);
  c_dir_pin_flip: cover property (step[0] && ctrl_ff[0].ext_dir && s2_ff.dir_in[0]);

  ////////////////////////////////////////////////////////////////////////////
  // further checks on chaining, reloads and the second module
  // each hardware check except the base latch flip excludes a software write in the same cycle, since writes win

  // an aux timer clocked by the core latch steps on the selected latch edge
  a_latch_clock: assert property ((ctrl_ff[0].mode == MODE_COUNTER && ctrl_ff[0].run
                                   && ctrl_ff[0].clk_latch && ctrl_ff[0].edge_sel[0]
                                   && role_t'(ctrl_ff[0].opt) == ROLE_NONE && core_rise && !we)
                                  |=> cnt_ff[0] != $past(cnt_ff[0]))
    else $error("aux_a missed a core latch clock");

  // counter mode without a pin edge leaves the count alone
  a_counter_idle: assert property ((ctrl_ff[0].mode == MODE_COUNTER && !ctrl_ff[0].clk_latch
                                    && role_t'(ctrl_ff[0].opt) == ROLE_NONE
                                    && !cin_r[0] && !cin_f[0] && !we) |=> $stable(cnt_ff[0]))
    else $error("aux_a counted without a pin edge");

  // the direction pin turns an up-counting timer downwards
  a_dir_pin: assert property ((ctrl_ff[0].mode == MODE_TIMER && ctrl_ff[0].ext_dir && !ctrl_ff[0].down
                               && role_t'(ctrl_ff[0].opt) == ROLE_NONE && s2_ff.dir_in[0] && step[0] && !we)
                              |=> cnt_ff[0] == 16'($past(cnt_ff[0]) - 16'h0001))
    else $error("aux_a ignored its direction pin");

  // an aux_a reload takes the aux_a value, which wins over aux_b
  a_pwm_load: assert property ((rld_ev[0] && !we) |=> cnt_ff[1] == $past(cnt_ff[0]))
    else $error("reload from aux_a wrong");

  // aux_b in reload role holds its value for the core
  a_aux_b_hold: assert property ((role_t'(ctrl_ff[2].opt) == ROLE_RELOAD && !we)
                                 |=> $stable(cnt_ff[2]))
    else $error("aux_b counted in reload role");

  // base latch inverts on every base wrap
  a_base_latch_flip: assert property (wrap[4] |=> base_latch_ff != $past(base_latch_ff))
    else $error("base latch missed a wrap");

  // a base wrap with reload enabled takes the capture register
  a_base_reload: assert property ((wrap[4] && ctrl_ff[4].opt[`GTU_OPT_RELOAD] && !we)
                                  |=> cnt_ff[4] == $past(capture_reload_register_ff))
    else $error("base timer not reloaded from capture register");

  // capture with clear enabled leaves the capture timer at zero
  a_cap_clear: assert property ((cap2 && ctrl_ff[3].opt[`GTU_OPT_CLEAR] && !we)
                                |=> cnt_ff[3] == 16'h0000)
    else $error("capture timer not cleared after capture");

  // core count pin edges capture when enabled
  a_core_pin_trig: assert property ((ctrl_ff[3].opt[`GTU_OPT_TRIG_IN] && (cin_r[1] || cin_f[1]) && !we)
                                    |=> capture_reload_register_ff == $past(cnt_ff[3]))
    else $error("core count pin edge did not capture");

  // core direction pin edges capture when enabled
  a_core_dir_trig: assert property ((ctrl_ff[3].gate_lvl && (din_r[1] || din_f[1]) && !we)
                                    |=> capture_reload_register_ff == $past(cnt_ff[3]))
    else $error("core direction pin edge did not capture");

  // software writes land at the strobe edge and read data stand one cycle
  a_count_write: assert property ((we && addr == 4'(`GTU_REG_CNT0 + 4'h1)) |=> cnt_ff[1] == $past(wdata))
    else $error("core count write lost");
  a_capture_reload_register_write: assert property ((we && addr == `GTU_REG_CAPTURE_RELOAD_REGISTER) |=> capture_reload_register_ff == $past(wdata))
    else $error("capture register write lost");
  a_rdata_idle: assert property (!re |=> rdata == 16'h0000)
    else $error("read data outside the read cycle");
endmodule : general_timer_unit

// ### src/gtu_defines.svh
// register offsets, reset values and timing steps of the general timer unit
`ifndef GTU_DEFINES_SVH
`define GTU_DEFINES_SVH
`define GTU_REG_CTRL0   4'h0
`define GTU_REG_CNT0    4'h5
`define GTU_REG_CAPTURE_RELOAD_REGISTER  4'ha
`define GTU_REG_STATUS  4'hb
`define GTU_CTRL_RST    16'h0000
`define GTU_CNT_RST     16'h0000
`define GTU_CNT_MAX     16'hffff
`define GTU_M1_STEP     10'h004
`define GTU_M2_STEP     10'h002
`define GTU_OPT_OE      0
`define GTU_OPT_RELOAD  1
`define GTU_OPT_CLEAR   0
`define GTU_OPT_TRIG_IN 1
`define GTU_STAT_CORE   0
`define GTU_STAT_BASE   1
`endif

// ### src/gtu_pkg.sv
// types shared by the general timer unit
package gtu_pkg;
  typedef enum logic [1:0] {MODE_TIMER, MODE_GATED, MODE_COUNTER, MODE_INCR} mode_t;
  typedef enum logic [1:0] {ROLE_NONE, ROLE_CAPTURE, ROLE_RELOAD, ROLE_SPARE} role_t;
  typedef enum logic [1:0] {TRIG_PIN, TRIG_LATCH_RISE, TRIG_LATCH_FALL, TRIG_OFF} trig_t;
  // one control word per timer, msb first; opt means role (aux), oe (core), oe/reload (base),
  // clear/trigger-on-core-input (capture timer); capture timer uses trig_sel as capture_input_pin edge select
  typedef struct packed {
    logic [1:0] trig_sel;
    logic       clk_latch;
    logic [1:0] opt;
    logic       gate_lvl;
    logic [1:0] edge_sel;
    logic [2:0] pre;
    logic       ext_dir;
    logic       down;
    logic       run;
    mode_t      mode;
  } ctrl_t;
  typedef struct packed {
    logic [4:0] cnt_in;
    logic [4:0] dir_in;
    logic       cap_in;
  } pins_t;
  function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
    return (sel[0] & r) | (sel[1] & f);
  endfunction : edge_hit
endpackage : gtu_pkg

// ### bench/pin_partner.sv
// far-side model of the timer pins: levels, pulses and a quadrature encoder
module pin_partner (
  input  wire logic      clock,
  output gtu_pkg::pins_t pins
);
  timeunit 1ns;
  timeprecision 1ps;
  int ph;
  initial begin
    pins = '0;
    ph   = 0;
  end
  // keep each level long enough for the input synchroniser and edge detect
  task automatic hold();
    repeat (8) @(posedge clock);
  endtask : hold
  // set one pin bit just after a rising edge, then let it settle
  task automatic lvl(input int b, input logic val);
    @(posedge clock);
    pins[b] <= val;
    hold();
  endtask : lvl
  // one high pulse on one pin bit
  task automatic pulse(input int b);
    lvl(b, 1'b1);
    lvl(b, 1'b0);
  endtask : pulse
  // n encoder steps on timer i, a on cnt_in and b on dir_in; negative n reverses
  task automatic quad(input int i, input int n);
    for (int k = 0; k < (n < 0 ? -n : n); k++) begin
      ph = (ph + (n < 0 ? 3 : 1)) % 4;
      @(posedge clock);
      pins.cnt_in[i] <= ph[1] ^ ph[0];
      pins.dir_in[i] <= ph[1];
      hold();
    end
  endtask : quad
endmodule : pin_partner

// ### bench/tb_top.sv
// self-checking bench for the general timer unit
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import gtu_pkg::*;
  logic        clock;
  logic        arst_n;
  pins_t       pins;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic        we;
  logic        re;
  logic [15:0] rdata;
  logic        core_out;
  logic        core_oe;
  logic        base_out;
  logic        base_oe;
  logic        wrap_p;
  logic [15:0] v;
  logic [15:0] c0;
  logic [15:0] c1;
  int          n;
  int          error_cnt = 0;
  int          n_tests   = 0;
  int          n_wrap    = 0;
  general_timer_unit i_dut (
    .clock              (clock),
    .arst_n             (arst_n),
    .pins               (pins),
    .addr               (addr),
    .wdata              (wdata),
    .we                 (we),
    .re                 (re),
    .rdata              (rdata),
    .core_toggle_output (core_out),
    .core_toggle_oe     (core_oe),
    .base_toggle_output (base_out),
    .base_toggle_oe     (base_oe),
    .base_wrap_pulse    (wrap_p)
  );
  pin_partner i_pins (
    .clock (clock),
    .pins  (pins)
  );
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // wraps handed to the compare unit
  always @(posedge clock) begin
    if (wrap_p === 1'b1) n_wrap <= n_wrap + 1;
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    we    <= 1'b1;
    @(posedge clock);
    we    <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    addr <= a;
    re   <= 1'b1;
    @(posedge clock);
    re   <= 1'b0;
    @(negedge clock);
    d = rdata;
  endtask : rd
  function automatic logic [15:0] ctl(mode_t md, logic rn, logic dn, logic [2:0] p,
                                      logic [1:0] es, logic [1:0] op, logic [1:0] tr);
    ctrl_t c;
    c          = '0;
    c.mode     = md;
    c.run      = rn;
    c.down     = dn;
    c.pre      = p;
    c.edge_sel = es;
    c.opt      = op;
    c.trig_sel = tr;
    return c;
  endfunction : ctl
  // two count reads exactly 40 clocks apart must differ by d
  task automatic meas(input int i, input logic [15:0] cw, input int d);
    wr(4'(5 + i), 16'h8000);
    wr(i[3:0], cw);
    rd(i[3:0], c0);
    chk("ctrl readback", cw, c0);
    rd(4'(5 + i), c0);
    repeat (38) @(posedge clock);
    rd(4'(5 + i), c1);
    chk("count step", 16'(c0 + d), c1);
    wr(i[3:0], 16'h0000);
  endtask : meas
  // clocks spent at the present toggle-latch level
  task automatic level_len(output int k);
    logic s;
    s = core_out;
    k = 0;
    while (core_out === s && k < 300) begin
      @(posedge clock);
      k++;
    end
    if (k >= 300) begin
      error_cnt++;
      $display("ERROR toggle level expected edge seen none");
    end
  endtask : level_len
  initial begin
    repeat (100000) @(posedge clock);
    error_cnt++;
    $display("ERROR run length expected end seen hang");
    give_verdict();
  end
  initial begin
    void'($urandom(32'hc959));
    arst_n = 1'b0;
    addr   = 4'h0;
    wdata  = 16'h0000;
    we     = 1'b0;
    re     = 1'b0;
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    for (int a = 0; a < 16; a++) begin
      rd(a[3:0], c0);
      chk("reset value", 16'h0000, c0);
    end
    wr(4'hc, 16'($urandom));
    rd(4'hc, c0);
    chk("unmapped", 16'h0000, c0);
    $display("test map done");
    meas(1, ctl(MODE_TIMER, 1, 0, 0, 0, 0, 0), 10);
    meas(1, ctl(MODE_TIMER, 1, 1, 0, 0, 0, 0), -10);
    meas(1, ctl(MODE_TIMER, 1, 0, 1, 0, 0, 0), 5);
    meas(0, ctl(MODE_TIMER, 1, 0, 0, 0, 0, 0), 10);
    meas(4, ctl(MODE_TIMER, 1, 0, 0, 0, 0, 0), 20);
    meas(4, ctl(MODE_TIMER, 1, 0, 1, 0, 0, 0), 10);
    i_pins.lvl(1, 1'b1);
    meas(0, ctl(MODE_TIMER, 1, 0, 0, 0, 0, 0) | 16'h0010, -10);
    i_pins.lvl(1, 1'b0);
    i_pins.lvl(8, 1'b1);
    meas(2, ctl(MODE_GATED, 1, 0, 0, 0, 0, 0) | 16'h0400, 10);
    i_pins.lvl(8, 1'b0);
    meas(2, ctl(MODE_GATED, 1, 0, 0, 0, 0, 0) | 16'h0400, 0);
    $display("test rates done");
    for (int e = 1; e < 4; e++) begin
      v = 16'($urandom);
      wr(4'h5, v);
      wr(4'h0, ctl(MODE_COUNTER, 1, 0, 0, e[1:0], 0, 0));
      repeat (3) i_pins.pulse(6);
      rd(4'h5, c0);
      chk("event count", 16'(v + (e == 3 ? 6 : 3)), c0);
    end
    v = {2'b01, 14'($urandom)};
    wr(4'h6, v);
    wr(4'h1, ctl(MODE_INCR, 1, 0, 0, 0, 0, 0));
    i_pins.quad(1, 5);
    rd(4'h6, c0);
    chk("encoder span", 16'(v + 5), c0);
    i_pins.quad(1, -5);
    rd(4'h6, c0);
    chk("encoder return", v, c0);
    wr(4'h1, 16'h0000);
    $display("test counting done");
    v = 16'($urandom);
    wr(4'h6, v);
    wr(4'h5, ~v);
    wr(4'h0, ctl(MODE_TIMER, 1, 0, 0, 2'b01, 2'b01, 0));
    i_pins.pulse(6);
    rd(4'h5, c0);
    chk("aux capture", v, c0);
    repeat (40) @(posedge clock);
    rd(4'h5, c0);
    chk("aux held", v, c0);
    wr(4'h0, 16'h0000);
    for (int k = 0; k < 3; k++) begin
      v = 16'($urandom);
      wr(4'h8, v);
      wr(4'h3, ctl(MODE_TIMER, 0, 0, 0, 0, k == 0 ? 2'b01 : (k == 1 ? 2'b10 : 2'b00), 2'b01)
               | (k == 2 ? 16'h0400 : 16'h0000));
      i_pins.pulse(k == 0 ? 0 : (k == 1 ? 7 : 2));
      rd(4'ha, c0);
      chk("capture reg", v, c0);
      rd(4'h8, c0);
      chk("capture timer", k == 0 ? 16'h0000 : v, c0);
    end
    $display("test capture done");
    wr(4'h6, 16'hfffe);
    wr(4'h1, ctl(MODE_TIMER, 1, 0, 0, 0, 2'b01, 0));
    wr(4'h9, 16'hfffe);
    wr(4'h4, ctl(MODE_TIMER, 1, 0, 0, 0, 2'b01, 0));
    repeat (16) @(posedge clock);
    rd(4'hb, c0);
    chk("status", 16'h0003, c0);
    chk("latch pins", 16'h000f, {12'h000, core_out, base_out, core_oe, base_oe});
    chk("wrap pulses", 16'h0001, 16'(n_wrap));
    wr(4'h4, 16'h0000);
    wr(4'h1, 16'h0000);
    wr(4'h5, 16'hfff0);
    wr(4'h7, 16'hfff8);
    wr(4'h0, ctl(MODE_TIMER, 0, 0, 0, 0, 2'b10, 2'b01));
    wr(4'h2, ctl(MODE_TIMER, 0, 0, 0, 0, 2'b10, 2'b10));
    wr(4'h6, 16'hfffc);
    wr(4'h1, ctl(MODE_TIMER, 1, 0, 0, 0, 2'b01, 0));
    level_len(n);
    repeat (2) begin
      level_len(n);
      chk("pwm level", 16'(4 * (32'h10000 - (core_out ? 32'hfff8 : 32'hfff0))), 16'(n));
    end
    $display("test toggle done");
    give_verdict();
  end
endmodule : tb_top
